// ### ctu_pkg.sv
package ctu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;

  // ----------------------------------------------------------------
  // Control register fields and reset
  // ----------------------------------------------------------------
  localparam int UNIT_ON_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int DELAY_GEN_ON_BIT = 12;
  localparam int HW_EDGE_SELECT_BIT = 11;
  localparam int EDGE_ORDER_ON_BIT = 10;
  localparam int SOURCE_GROUND_BIT = 9;
  localparam int ADC_TRIGGER_ON_BIT = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hBF00;

  // Status register: edge_status_flags in bits 1:0
  localparam int EDGE1_BIT = 0;
  localparam int EDGE2_BIT = 1;
  localparam logic [1:0] FLAGS_RESET = 2'h0;

  // Control word as stored, bit 15 first
  typedef struct packed {
    logic unit_on;
    logic rsvd_14;
    logic idle_stop;
    logic delay_gen_on;
    logic hw_edge_select;
    logic edge_order_on;
    logic source_ground;
    logic adc_trigger_on;
    logic [7:0] rsvd_lo;
  } ctrl_s;

  // One bit for each edge channel
  typedef struct packed {
    logic edge2;
    logic edge1;
  } edge_pair_s;

endpackage : ctu_pkg

// ### edge_sync_detect.sv
module edge_sync_detect (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Asynchronous edge pins
  input ctu_pkg::edge_pair_s pin_i,
  // One-cycle rising-edge pulses
  output ctu_pkg::edge_pair_s rise_o
);
  import ctu_pkg::*;

  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] prev;

  // ----------------------------------------------------------------
  // Two-stage synchroniser and edge detect per channel
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else begin
          meta[g] <= pin_i[g];
          sync[g] <= meta[g];
          prev[g] <= sync[g];
        end
      end
    end
  endgenerate

  // Only the second stage feeds the detector
  assign rise_o = edge_pair_s'(sync & ~prev);

endmodule : edge_sync_detect

// ### charge_time_unit_control.sv
// What this block does
// - Unit runs only while unit_on, bit 15, is one.
// - With idle_stop, bit 13, the unit halts while the processor idles.
// - delay_gen_on, bit 12, turns edge delay generation on or off.
// - hw_edge_select, bit 11: edges from timers and pins, else software flags.
// - edge_order_on, bit 10: edge 2 ignored until edge 1 occurred.
// - source_ground, bit 9, grounds the current source output.
// - adc_trigger_on, bit 8, lets the unit start ADC conversions.
// - Bits 14 and 7 to 0 read zero and ignore writes.
module charge_time_unit_control (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Edge sources and processor state
  input ctu_pkg::edge_pair_s EDGE_PIN_I,
  input ctu_pkg::edge_pair_s TIMER_EDGE_I,
  input wire logic IDLE_I,
  // Analog and ADC controls
  output logic CURRENT_ON_O,
  output logic SRC_GND_O,
  output logic DELAY_GEN_O,
  output logic ADC_SOC_O
);
  import ctu_pkg::*;

  ctrl_s ctrl;
  ctrl_s next_ctrl;
  edge_pair_s flags;
  edge_pair_s next_flags;
  edge_pair_s pin_rise;
  edge_pair_s evt;
  logic [31:0] next_prdata;
  logic next_current_on;
  logic next_src_gnd;
  logic next_delay_gen;
  logic next_adc_soc;
  logic run;
  logic setup;
  logic wr_ctrl;
  logic wr_stat;
  logic mapped;
  logic set2;

  // ----------------------------------------------------------------
  // Edge pin synchronisers
  // ----------------------------------------------------------------
  edge_sync_detect u_sync (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .pin_i(EDGE_PIN_I),
    .rise_o(pin_rise)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero-wait slave: access phase always completes
  assign setup = PSEL_I && !PENABLE_I;
  assign mapped = (PADDR_I == CTRL_ADDR) || (PADDR_I == STAT_ADDR);
  assign wr_ctrl = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == CTRL_ADDR);
  assign wr_stat = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == STAT_ADDR);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

  // Read data captured in the setup cycle
  always_comb begin
    next_prdata = PRDATA_O;
    if (setup) begin
      if (PADDR_I == CTRL_ADDR) begin
        next_prdata = {16'h0000, ctrl};
      end else if (PADDR_I == STAT_ADDR) begin
        next_prdata = {30'h0000_0000, flags};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PRDATA_O <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Reserved positions masked off on write
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = ctrl_s'(PWDATA_I[15:0] & CTRL_WMASK);
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl <= ctrl_s'(CTRL_RESET);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Edge events and status flags
  // ----------------------------------------------------------------
  // Running unless disabled or halted in idle
  assign run = ctrl.unit_on && !(ctrl.idle_stop && IDLE_I);

  // Hardware sources or software writes of ones
  always_comb begin
    if (ctrl.hw_edge_select) begin
      evt = pin_rise | TIMER_EDGE_I;
    end else if (wr_stat) begin
      evt = edge_pair_s'(PWDATA_I[1:0]);
    end else begin
      evt = edge_pair_s'(2'h0);
    end
  end

  // Edge 2 gated by edge 1 when ordering is on
  assign set2 = evt.edge2 && (!ctrl.edge_order_on || flags.edge1);

  // Writing zero clears a flag; a same-cycle edge wins
  always_comb begin
    next_flags = flags;
    if (!ctrl.unit_on) begin
      next_flags = edge_pair_s'(FLAGS_RESET);
    end else if (run) begin
      if (wr_stat) begin
        next_flags = edge_pair_s'(PWDATA_I[1:0] & flags);
      end
      if (evt.edge1) begin
        next_flags.edge1 = 1'b1;
      end
      if (set2) begin
        next_flags.edge2 = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      flags <= edge_pair_s'(FLAGS_RESET);
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Analog and ADC outputs
  // ----------------------------------------------------------------
  // Current flows between edge 1 and edge 2
  always_comb begin
    next_src_gnd = ctrl.source_ground;
    next_current_on = run && flags.edge1 && !flags.edge2 && !ctrl.source_ground;
    next_delay_gen = run && ctrl.delay_gen_on && flags.edge1 && !flags.edge2;
    next_adc_soc = run && ctrl.adc_trigger_on && set2 && !flags.edge2;
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CURRENT_ON_O <= 1'b0;
      SRC_GND_O <= 1'b0;
      DELAY_GEN_O <= 1'b0;
      ADC_SOC_O <= 1'b0;
    end else begin
      CURRENT_ON_O <= next_current_on;
      SRC_GND_O <= next_src_gnd;
      DELAY_GEN_O <= next_delay_gen;
      ADC_SOC_O <= next_adc_soc;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_unit_off_quiet: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    !ctrl.unit_on |=> (flags == 2'h0) && !CURRENT_ON_O && !ADC_SOC_O && !DELAY_GEN_O)
    else $error("unit off but activity seen");

  chk_idle_freeze: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (ctrl.unit_on && ctrl.idle_stop && IDLE_I) |=> $stable(flags) && !CURRENT_ON_O)
    else $error("flags moved while halted in idle");

  chk_delay_gate: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    DELAY_GEN_O |-> $past(ctrl.delay_gen_on) && $past(flags.edge1))
    else $error("delay output without enable");

  chk_sw_edges_only: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (!ctrl.hw_edge_select && !wr_stat) |=> (flags & ~$past(flags)) == 2'h0)
    else $error("edge flag set without software write");

  chk_edge_order: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (ctrl.edge_order_on && !flags.edge1 && !flags.edge2) |=> !flags.edge2)
    else $error("edge 2 taken before edge 1");

  chk_source_ground: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    ctrl.source_ground |=> SRC_GND_O && !CURRENT_ON_O)
    else $error("source not grounded");

  chk_adc_trigger: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    ADC_SOC_O |-> $past(ctrl.adc_trigger_on) && flags.edge2 ##1 !ADC_SOC_O)
    else $error("bad conversion trigger");

  chk_reserved_zero: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    wr_ctrl |=> (ctrl.rsvd_14 == 1'b0) && (ctrl.rsvd_lo == 8'h00) ##1
      (PRDATA_O[14] == 1'b0 || !$past(setup && PADDR_I == CTRL_ADDR)))
    else $error("reserved control bit set");

endmodule : charge_time_unit_control

// ### ctu_far_model.sv
module ctu_far_model (
  // Clock
  input wire logic clk_i,
  // Conversion start from the unit
  input wire logic adc_soc_i,
  // Discharge state of the current source
  input wire logic src_gnd_i,
  // Edge sources toward the unit
  output ctu_pkg::edge_pair_s timer_edge_o,
  output ctu_pkg::edge_pair_s edge_pin_o,
  // ADC sample phase and start count
  output logic sampling_o,
  output int soc_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ctu_pkg::*;

  // ----------------------------------------------------------------
  // Edge sources, quiet at time zero
  // ----------------------------------------------------------------
  initial begin
    timer_edge_o = 2'h0;
    edge_pin_o = 2'h0;
    sampling_o = 1'b0;
    soc_count_o = 0;
  end

  // ADC held sampling while the source is grounded
  always @(posedge clk_i) begin
    if (src_gnd_i === 1'b1) begin
      sampling_o <= 1'b1;
    end else if (adc_soc_i === 1'b1) begin
      sampling_o <= 1'b0;
    end
  end

  // Count ADC start pulses seen at the clock
  always @(posedge clk_i) begin
    if (adc_soc_i === 1'b1) begin
      soc_count_o <= soc_count_o + 1;
    end
  end

  // One-cycle timer pulse
  task automatic pulse_timer(input edge_pair_s p);
    @(posedge clk_i);
    timer_edge_o <= p;
    @(posedge clk_i);
    timer_edge_o <= 2'h0;
  endtask : pulse_timer

  // Pin rises, holds a few cycles, then falls
  task automatic raise_pin(input edge_pair_s p);
    @(posedge clk_i);
    edge_pin_o <= p;
    repeat (6) @(posedge clk_i);
    edge_pin_o <= 2'h0;
  endtask : raise_pin
endmodule : ctu_far_model

// ### charge_time_unit_control_tb.sv
module charge_time_unit_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ctu_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic idle;
  logic sampling;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic current_on;
  logic src_gnd;
  logic delay_gen;
  logic adc_soc;
  edge_pair_s timer_edge;
  edge_pair_s edge_pin;
  int soc_count;
  logic [31:0] rdata;
  logic rerr;
  int num_errors = 0;
  int tests_run = 0;

  // Clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  charge_time_unit_control charge_time_unit_control_inst (
    .MCLK_I(mclk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EDGE_PIN_I(edge_pin),
    .TIMER_EDGE_I(timer_edge), .IDLE_I(idle), .CURRENT_ON_O(current_on),
    .SRC_GND_O(src_gnd), .DELAY_GEN_O(delay_gen), .ADC_SOC_O(adc_soc)
  );

  ctu_far_model ctu_far_model_inst (
    .clk_i(mclk), .adc_soc_i(adc_soc), .src_gnd_i(src_gnd), .timer_edge_o(timer_edge),
    .edge_pin_o(edge_pin), .sampling_o(sampling), .soc_count_o(soc_count)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rdata, exp);
  endtask : rd_chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_n

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    idle <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd_chk("ctrl reset", CTRL_ADDR, 32'h0000_0000);
    rd_chk("flags reset", STAT_ADDR, 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_FFFF);
    rd_chk("ctrl mask", CTRL_ADDR, 32'h0000_BF00);
    rd_chk("unmapped data", 12'hFFC, 32'h0000_0000);
    chk("unmapped err", 32'(rerr), 32'h0000_0001);
    // Hardware edges with delay and ADC trigger
    apb(1'b1, CTRL_ADDR, 32'h0000_8200);
    apb(1'b1, CTRL_ADDR, 32'h0000_9900);
    apb(1'b1, STAT_ADDR, 32'h0000_0000);
    ctu_far_model_inst.pulse_timer(2'h1);
    wait_n(3);
    chk("current on", 32'(current_on), 32'h0000_0001);
    chk("delay gen on", 32'(delay_gen), 32'h0000_0001);
    ctu_far_model_inst.pulse_timer(2'h2);
    wait_n(3);
    chk("soc count", 32'(soc_count), 32'h0000_0001);
    chk("current off", 32'(current_on), 32'h0000_0000);
    rd_chk("flags both", STAT_ADDR, 32'h0000_0003);
    // Edge order: edge 2 first is ignored, then pin edge 1
    apb(1'b1, STAT_ADDR, 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_8C00);
    ctu_far_model_inst.pulse_timer(2'h2);
    rd_chk("order blocks", STAT_ADDR, 32'h0000_0000);
    ctu_far_model_inst.raise_pin(2'h1);
    chk("delay gen off", 32'(delay_gen), 32'h0000_0000);
    ctu_far_model_inst.raise_pin(2'h2);
    rd_chk("order passes", STAT_ADDR, 32'h0000_0003);
    apb(1'b1, STAT_ADDR, 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_8800);
    ctu_far_model_inst.pulse_timer(2'h2);
    rd_chk("no order", STAT_ADDR, 32'h0000_0002);
    chk("no trigger", 32'(soc_count), 32'h0000_0001);
    // Discharge before measuring, then software edges
    apb(1'b1, STAT_ADDR, 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_8200);
    apb(1'b1, STAT_ADDR, 32'h0000_0001);
    wait_n(3);
    chk("grounded", 32'(src_gnd), 32'h0000_0001);
    chk("grounded off", 32'(current_on), 32'h0000_0000);
    chk("adc sampling", 32'(sampling), 32'h0000_0001);
    apb(1'b1, CTRL_ADDR, 32'h0000_8000);
    wait_n(3);
    chk("ungrounded", 32'(src_gnd), 32'h0000_0000);
    chk("sw current", 32'(current_on), 32'h0000_0001);
    ctu_far_model_inst.pulse_timer(2'h2);
    rd_chk("hw ignored", STAT_ADDR, 32'h0000_0001);
    // Idle halt and idle run
    apb(1'b1, CTRL_ADDR, 32'h0000_A000);
    idle <= 1'b1;
    apb(1'b1, STAT_ADDR, 32'h0000_0003);
    rd_chk("idle frozen", STAT_ADDR, 32'h0000_0001);
    chk("idle current", 32'(current_on), 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_8000);
    apb(1'b1, STAT_ADDR, 32'h0000_0003);
    rd_chk("idle runs", STAT_ADDR, 32'h0000_0003);
    idle <= 1'b0;
    apb(1'b1, STAT_ADDR, 32'h0000_0001);
    wait_n(2);
    chk("on before off", 32'(current_on), 32'h0000_0001);
    apb(1'b1, CTRL_ADDR, 32'h0000_0000);
    rd_chk("off clears", STAT_ADDR, 32'h0000_0000);
    chk("off current", 32'(current_on), 32'h0000_0000);
    // Reset in mid-run returns registers and outputs to rest
    apb(1'b1, CTRL_ADDR, 32'hFFFF_FFFF);
    wait_n(2);
    chk("gnd before reset", 32'(src_gnd), 32'h0000_0001);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd_chk("ctrl rerun", CTRL_ADDR, 32'h0000_0000);
    rd_chk("flags rerun", STAT_ADDR, 32'h0000_0000);
    chk("gnd rerun", 32'(src_gnd), 32'h0000_0000);
    end_sim();
  end
endmodule : charge_time_unit_control_tb
